/* design/wdt_params.svh */
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
// Register byte addresses on the AXI4-Lite slave.
`define WDT_ADDR_CTRL 8'h00
`define WDT_ADDR_SEL 8'h04
`define WDT_ADDR_KEY 8'h08
`define WDT_ADDR_IRQEN 8'h0C
`define WDT_ADDR_STAT 8'h10
`define WDT_ADDR_ICLR 8'h14
`define WDT_ADDR_IEN 8'h18
// Control register bit positions.
`define WDT_BIT_RESTART 0
`define WDT_BIT_RST_EN 1
`define WDT_BIT_CAUSE 2
`define WDT_BIT_TIMEOUT 3
// Extended interrupt enable bit for the watchdog.
`define WDT_BIT_DOG_IRQ_EN 4
// Timed access unlock key bytes.
`define WDT_KEY_FIRST 8'hAA
`define WDT_KEY_SECOND 8'h55
// Cycles the unlock stays open after the second key byte.
`define WDT_UNLOCK_WINDOW 3'h4
// Interval exponents for select codes 00..11.
`define WDT_EXP_0 17
`define WDT_EXP_1 20
`define WDT_EXP_2 23
`define WDT_EXP_3 26
// Clocks from time-out to reset, and machine cycle length in clocks.
`define WDT_RESET_DELAY 512
`define WDT_CLK_PER_MCYCLE 4
`define WDT_RESET_MCYCLES 2
`define WDT_SEL_RESET 2'h0
`endif

/* design/wdt_pkg.sv */
package wdt_pkg;
    typedef enum logic [2:0]
    {
        WDT_RUN = 3'b001,
        WDT_GRACE = 3'b010,
        WDT_RESET = 3'b100
    } wdt_state_t;
endpackage

/* design/wdt_top.sv */
`timescale 1ns/1ps
`include "wdt_params.svh"
// Functional notes
// - Interval select 00/01/10/11 gives 2^17, 2^20, 2^23, 2^26 clocks.
// - Each elapsed interval sets the timeout flag, control bit 3.
// - 512 clocks after time-out, reset fires if enabled and no restart came.
// - Watchdog reset lasts two machine cycles and sets the reset-cause flag.
// - Writing 1 to restart clears and restarts the count; bit self-clears.
// - Watchdog interrupt dog_irq requested only with timeout flag, dog irq enable and global enable.
// - Timeout flag cleared by software write or by any reset.
// - Reset-cause flag stays until software clears it; power-on or power-fail reset clears it.
// - With reset enable at 0 the watchdog never touches the reset-cause flag.
// - Reset enable low disables only the reset; counting and flagging go on.
// - Power-on or power-fail reset disables the watchdog timer.
// - Watchdog's own reset does not disable it; count restarts from zero.
// - Interval select resets to the shortest setting, 2^17 clocks.
// - Protected bits change only after the AAh then 55h key writes.
// - Timeout flag sets again after every further full interval.
// - Interrupt and reset paths are controlled independently.
module wdt_top import wdt_pkg::*; #(
    parameter int CNT_W = 27,
    parameter int EXP_0 = `WDT_EXP_0,
    parameter int EXP_1 = `WDT_EXP_1,
    parameter int EXP_2 = `WDT_EXP_2,
    parameter int EXP_3 = `WDT_EXP_3,
    parameter int RESET_DELAY = `WDT_RESET_DELAY
)
(
    // Clock, reset and enable.
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Power-fail reset pulse and processor global interrupt enable.
    input wire logic power_fail_rst,
    input wire logic global_irq_enable,
    // AXI4-Lite write address.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Outputs to the system.
    output logic dog_irq,
    output logic dog_sys_reset,
    output logic irq
);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int RST_CYC = `WDT_CLK_PER_MCYCLE * `WDT_RESET_MCYCLES;

    function automatic logic [CNT_W-1:0] interval_of(input logic [1:0] sel);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        case (sel)
            2'h0: interval_of = one << EXP_0;
            2'h1: interval_of = one << EXP_1;
            2'h2: interval_of = one << EXP_2;
            default: interval_of = one << EXP_3;
        endcase
    endfunction

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
        addr_hit = (a[7:2] == reg_addr[7:2]);
    endfunction

    // Register state.
    logic enabled_r;
    logic [1:0] interval_sel_r;
    logic dog_reset_enable_r;
    logic timeout_flag_r;
    logic dog_reset_cause_flag_r;
    logic dog_restart_r;
    logic dog_irq_enable_r;
    logic key_first_seen_r;
    logic [2:0] unlock_cnt_r;
    logic [CNT_W-1:0] count_r;
    logic [9:0] grace_cnt_r;
    logic [3:0] rst_cnt_r;
    wdt_state_t state_r;
    wdt_state_t state_nxt;
    logic [3:0] ev_status_r;
    logic [3:0] ev_enable_r;

    // Bus handshake state.
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Write decode.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_r || aw_take;
    wire w_have = w_held_r || w_take;
    wire [7:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
    wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
    wire wr_fire = clk_en && aw_have && w_have && !bvalid_r;
    wire wr_lane0 = wr_fire && wr_strb[0];
    wire wr_ctrl = wr_lane0 && addr_hit(wr_addr, `WDT_ADDR_CTRL);
    wire wr_sel = wr_lane0 && addr_hit(wr_addr, `WDT_ADDR_SEL);
    wire wr_key = wr_lane0 && addr_hit(wr_addr, `WDT_ADDR_KEY);
    wire wr_irqen = wr_lane0 && addr_hit(wr_addr, `WDT_ADDR_IRQEN);
    wire wr_iclr = wr_lane0 && addr_hit(wr_addr, `WDT_ADDR_ICLR);
    wire wr_ien = wr_lane0 && addr_hit(wr_addr, `WDT_ADDR_IEN);
    wire wr_mapped = addr_hit(wr_addr, `WDT_ADDR_CTRL) || addr_hit(wr_addr, `WDT_ADDR_SEL)
        || addr_hit(wr_addr, `WDT_ADDR_KEY) || addr_hit(wr_addr, `WDT_ADDR_IRQEN)
        || addr_hit(wr_addr, `WDT_ADDR_STAT) || addr_hit(wr_addr, `WDT_ADDR_ICLR)
        || addr_hit(wr_addr, `WDT_ADDR_IEN);

    // Timed access: the unlock is a short count that runs out on its own.
    wire unlocked = (unlock_cnt_r != 3'h0);
    wire prot_wr = wr_ctrl && unlocked;
    wire restart_req = prot_wr && wr_data[`WDT_BIT_RESTART];

    // Counter and time-out.
    wire [CNT_W-1:0] interval = interval_of(interval_sel_r);
    wire timeout_tick = enabled_r && (count_r == interval - 1'b1);
    wire grace_done = (grace_cnt_r == 10'(RESET_DELAY - 1));
    wire fire_reset = (state_r == WDT_GRACE) && grace_done && dog_reset_enable_r
        && !restart_req;
    wire rst_done = (rst_cnt_r == 4'(RST_CYC - 1));

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            WDT_RUN:
                if (timeout_tick && !restart_req)
                    state_nxt = WDT_GRACE;
            WDT_GRACE:
                if (restart_req)
                    state_nxt = WDT_RUN;
                else if (fire_reset)
                    state_nxt = WDT_RESET;
                else if (grace_done)
                    state_nxt = WDT_RUN;
            WDT_RESET:
                if (rst_done)
                    state_nxt = WDT_RUN;
            default:
                state_nxt = WDT_RUN;
        endcase
    end

    // Watchdog core.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enabled_r <= 1'b0;
            state_r <= WDT_RUN;
            count_r <= '0;
            grace_cnt_r <= 10'h000;
            rst_cnt_r <= 4'h0;
            timeout_flag_r <= 1'b0;
            dog_reset_cause_flag_r <= 1'b0;
            dog_reset_enable_r <= 1'b0;
            dog_restart_r <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            dog_restart_r <= 1'b0;
            if (power_fail_rst)
            begin
                enabled_r <= 1'b0;
                state_r <= WDT_RUN;
                count_r <= '0;
                timeout_flag_r <= 1'b0;
                dog_reset_cause_flag_r <= 1'b0;
                dog_reset_enable_r <= 1'b0;
            end
            else
            begin
                if (restart_req || state_r == WDT_RESET)
                    count_r <= '0;
                else if (timeout_tick)
                    count_r <= '0;
                else if (enabled_r)
                    count_r <= count_r + 1'b1;
                if (restart_req)
                begin
                    enabled_r <= 1'b1;
                    dog_restart_r <= 1'b1;
                end
                grace_cnt_r <= (state_r == WDT_GRACE) ? grace_cnt_r + 10'h001 : 10'h000;
                rst_cnt_r <= (state_r == WDT_RESET) ? rst_cnt_r + 4'h1 : 4'h0;
                if (timeout_tick)
                    timeout_flag_r <= 1'b1;
                else if (state_r == WDT_RESET)
                    timeout_flag_r <= 1'b0;
                else if (prot_wr && !wr_data[`WDT_BIT_TIMEOUT])
                    timeout_flag_r <= 1'b0;
                if (fire_reset)
                    dog_reset_cause_flag_r <= 1'b1;
                else if (wr_ctrl && !wr_data[`WDT_BIT_CAUSE])
                    dog_reset_cause_flag_r <= 1'b0;
                if (prot_wr)
                    dog_reset_enable_r <= wr_data[`WDT_BIT_RST_EN];
            end
        end
    end

    // Unlock sequence, select, enables and event status.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_first_seen_r <= 1'b0;
            unlock_cnt_r <= 3'h0;
            interval_sel_r <= `WDT_SEL_RESET;
            dog_irq_enable_r <= 1'b0;
            ev_status_r <= 4'h0;
            ev_enable_r <= 4'h0;
        end
        else if (clk_en)
        begin
            if (wr_key)
            begin
                key_first_seen_r <= (wr_data[7:0] == `WDT_KEY_FIRST);
                if (key_first_seen_r && wr_data[7:0] == `WDT_KEY_SECOND)
                    unlock_cnt_r <= `WDT_UNLOCK_WINDOW;
            end
            else if (unlocked)
                unlock_cnt_r <= unlock_cnt_r - 3'h1;
            if (wr_sel)
                interval_sel_r <= wr_data[1:0];
            if (wr_irqen)
                dog_irq_enable_r <= wr_data[`WDT_BIT_DOG_IRQ_EN];
            if (wr_ien)
                ev_enable_r <= wr_data[3:0];
            // Set wins over a simultaneous clear.
            ev_status_r <= (ev_status_r & ~(wr_iclr ? wr_data[3:0] : 4'h0))
                | {restart_req, state_r == WDT_GRACE && state_nxt == WDT_RUN && !restart_req,
                   fire_reset, timeout_tick};
        end
    end

    assign dog_irq = timeout_flag_r && dog_irq_enable_r && global_irq_enable;
    assign dog_sys_reset = (state_r == WDT_RESET);
    assign irq = |(ev_status_r & ev_enable_r);

    // Read decode.
    wire [31:0] ctrl_view = {28'h0000000, timeout_flag_r, dog_reset_cause_flag_r,
        dog_reset_enable_r, dog_restart_r};
    wire [7:0] rd_addr = s_axi_araddr;
    wire rd_mapped = addr_hit(rd_addr, `WDT_ADDR_CTRL) || addr_hit(rd_addr, `WDT_ADDR_SEL)
        || addr_hit(rd_addr, `WDT_ADDR_KEY) || addr_hit(rd_addr, `WDT_ADDR_IRQEN)
        || addr_hit(rd_addr, `WDT_ADDR_STAT) || addr_hit(rd_addr, `WDT_ADDR_ICLR)
        || addr_hit(rd_addr, `WDT_ADDR_IEN);
    wire [31:0] rd_value =
        addr_hit(rd_addr, `WDT_ADDR_CTRL) ? ctrl_view :
        addr_hit(rd_addr, `WDT_ADDR_SEL) ? {30'h00000000, interval_sel_r} :
        addr_hit(rd_addr, `WDT_ADDR_IRQEN) ? {27'h0000000, dog_irq_enable_r, 4'h0} :
        addr_hit(rd_addr, `WDT_ADDR_STAT) ? {28'h0000000, ev_status_r} :
        addr_hit(rd_addr, `WDT_ADDR_IEN) ? {28'h0000000, ev_enable_r} :
        32'h00000000;

    // Readies drop while frozen, so no request is accepted that the halted logic would lose.
    assign s_axi_awready = clk_en && !aw_held_r && !bvalid_r;
    assign s_axi_wready = clk_en && !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = clk_en && !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Bus slave handshakes.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (wr_fire)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else
            begin
                if (aw_take)
                begin
                    aw_held_r <= 1'b1;
                    awaddr_r <= s_axi_awaddr;
                end
                if (w_take)
                begin
                    w_held_r <= 1'b1;
                    wdata_r <= s_axi_wdata;
                    wstrb_r <= s_axi_wstrb;
                end
                if (bvalid_r && s_axi_bready)
                    bvalid_r <= 1'b0;
            end
            if (s_axi_arvalid && !rvalid_r)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_value;
                rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid_r && s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end
endmodule // wdt_top

/* tb/wdt_asserts.sv */
`timescale 1ns/1ps
module wdt_asserts (
    // Clock, reset and system inputs.
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic power_fail_rst,
    input wire logic global_irq_enable,
    // Bus handshakes.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Watchdog outputs.
    input wire logic dog_irq,
    input wire logic dog_sys_reset
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_irq_gate: assert property (dog_irq |-> global_irq_enable)
        else $error("dog irq without global enable");
    chk_rst_width: assert property ($rose(dog_sys_reset) |-> dog_sys_reset [*8] ##1 !dog_sys_reset)
        else $error("dog reset width wrong");
    chk_rst_gap: assert property ($fell(dog_sys_reset) |-> !dog_sys_reset [*8])
        else $error("dog reset too soon after previous");
    chk_pf_quiet: assert property (power_fail_rst |=> (!dog_irq && !dog_sys_reset) [*8])
        else $error("dog active after power fail");
    chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_b_follow: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("write response missing");
    chk_r_follow: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
endmodule // wdt_asserts
bind wdt_top wdt_asserts u_wdt_asserts (.*);

/* tb/wdt_cpu.sv */
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_cpu (
    // Clock.
    input wire logic sys_clk,
    // Write channels.
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels.
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    logic [1:0] last_bresp;
    initial
    begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
    end
    // Released payload is inverted so a stale value can never pass for a live one.
    task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        fork
            begin
                do @(posedge sys_clk); while (!s_axi_awready);
                s_axi_awvalid <= 1'h0;
                s_axi_awaddr <= ~a;
            end
            begin
                do @(posedge sys_clk); while (!s_axi_wready);
                s_axi_wvalid <= 1'h0;
                s_axi_wdata <= ~d;
            end
        join
        do @(posedge sys_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        last_bresp = s_axi_bresp;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wrs(a, d, 4'h1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        s_axi_araddr <= ~a;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic unlock();
        wr(`WDT_ADDR_KEY, {24'h0, `WDT_KEY_FIRST});
        wr(`WDT_ADDR_KEY, {24'h0, `WDT_KEY_SECOND});
    endtask
    // Back-to-back writes keep the control write inside the short unlock window.
    task automatic prot(input logic [31:0] d);
        unlock();
        wr(`WDT_ADDR_CTRL, d);
    endtask
endmodule // wdt_cpu

/* tb/wdt_tb_top.sv */
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_tb_top;
    logic sys_clk, rst_n, clk_en, power_fail_rst, global_irq_enable, dog_irq, dog_sys_reset, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_total = 0, checked = 0, cyc = 0, t0, iv;
    // Intervals of 16 to 128 clocks and a 16 clock grace keep the run short.
    wdt_top #(.EXP_0(4), .EXP_1(5), .EXP_2(6), .EXP_3(7), .RESET_DELAY(16)) u_wdt_top (.*);
    wdt_cpu u_wdt_cpu (.*);
    always #12.5 sys_clk = ~sys_clk;
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s exp %0h seen %0h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        u_wdt_cpu.rd(a, rv, rr);
        check($sformatf("reg %0h", a), rv & m, e);
        check("resp", rr, {a == 8'h40, 1'h0});
    endtask
    task automatic wait_hi(input bit r, input int lim);
        repeat (lim)
        begin
            if ((r ? dog_sys_reset : dog_irq) === 1'h1)
                break;
            @(posedge sys_clk);
        end
    endtask
    initial
    begin
        sys_clk = 1'h0;
        rst_n = 1'h0;
        clk_en = 1'h1;
        power_fail_rst = 1'h0;
        global_irq_enable = 1'h1;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'h1;
        rdc(`WDT_ADDR_CTRL, 32'h0, 32'hF);
        rdc(`WDT_ADDR_SEL, 32'h0, 32'h3);
        rdc(8'h40, 32'h0, 32'hFFFFFFFF);
        u_wdt_cpu.wr(8'h40, 32'h0);
        check("bresp", u_wdt_cpu.last_bresp, 32'h2);
        // A write with lane 0 disabled must leave the select untouched.
        u_wdt_cpu.wrs(`WDT_ADDR_SEL, 32'h3, 4'h0);
        rdc(`WDT_ADDR_SEL, 32'h0, 32'h3);
        u_wdt_cpu.wr(`WDT_ADDR_CTRL, 32'h1);
        u_wdt_cpu.unlock();
        repeat (6) @(posedge sys_clk);
        u_wdt_cpu.wr(`WDT_ADDR_CTRL, 32'h1);
        repeat (200) @(posedge sys_clk);
        rdc(`WDT_ADDR_CTRL, 32'h0, 32'hB);
        u_wdt_cpu.wr(`WDT_ADDR_IRQEN, 32'h10);
        check("bresp", u_wdt_cpu.last_bresp, 32'h0);
        for (int s = 0; s < 4; s++)
        begin
            iv = 1 << (4 + s);
            u_wdt_cpu.wr(`WDT_ADDR_SEL, s);
            u_wdt_cpu.prot(32'h1);
            wait_hi(0, 300);
            t0 = cyc;
            u_wdt_cpu.prot(32'h0);
            check("clear", dog_irq, 1'h0);
            wait_hi(0, 300);
            check("period", cyc - t0 >= iv - 1 && cyc - t0 <= iv + 1, 1'h1);
        end
        rdc(`WDT_ADDR_CTRL, 32'h8, 32'h9);
        global_irq_enable <= 1'h0;
        repeat (2) @(posedge sys_clk);
        check("gate", dog_irq, 1'h0);
        global_irq_enable <= 1'h1;
        u_wdt_cpu.wr(`WDT_ADDR_IEN, 32'h1);
        check("irq", irq, 1'h1);
        rdc(`WDT_ADDR_STAT, 32'h9, 32'h9);
        u_wdt_cpu.wr(`WDT_ADDR_IEN, 32'h0);
        check("mask", irq, 1'h0);
        u_wdt_cpu.wr(`WDT_ADDR_IEN, 32'hF);
        u_wdt_cpu.wr(`WDT_ADDR_ICLR, 32'hF);
        check("unmask", irq, 1'h0);
        rdc(`WDT_ADDR_STAT, 32'h0, 32'hF);
        u_wdt_cpu.wr(`WDT_ADDR_SEL, 32'h0);
        u_wdt_cpu.wr(`WDT_ADDR_IRQEN, 32'h0);
        u_wdt_cpu.prot(32'h3);
        t0 = cyc;
        wait_hi(1, 100);
        check("grace", cyc - t0 >= 29 && cyc - t0 <= 35, 1'h1);
        repeat (12) @(posedge sys_clk);
        rdc(`WDT_ADDR_CTRL, 32'h6, 32'hE);
        wait_hi(1, 60);
        check("rerun", dog_sys_reset, 1'h1);
        u_wdt_cpu.wr(`WDT_ADDR_IRQEN, 32'h10);
        wait_hi(0, 60);
        // Writing the cause bit as 1 keeps the flag, since only a 0 clears it.
        // The shorter wait leaves the locked clear and its read ahead of the next reset.
        u_wdt_cpu.prot(32'h7);
        wait_hi(1, 20);
        check("kept", dog_sys_reset, 1'h0);
        rdc(`WDT_ADDR_CTRL, 32'h4, 32'h4);
        u_wdt_cpu.wr(`WDT_ADDR_CTRL, 32'h0);
        rdc(`WDT_ADDR_CTRL, 32'h2, 32'h6);
        power_fail_rst <= 1'h1;
        @(posedge sys_clk);
        power_fail_rst <= 1'h0;
        rdc(`WDT_ADDR_CTRL, 32'h0, 32'hD);
        repeat (100) @(posedge sys_clk);
        rdc(`WDT_ADDR_CTRL, 32'h0, 32'h8);
        u_wdt_cpu.prot(32'h1);
        wait_hi(1, 80);
        check("no reset", dog_sys_reset, 1'h0);
        rdc(`WDT_ADDR_CTRL, 32'h8, 32'hE);
        u_wdt_cpu.prot(32'h1);
        clk_en <= 1'h0;
        repeat (40) @(posedge sys_clk);
        clk_en <= 1'h1;
        check("frozen", dog_irq, 1'h0);
        wait_hi(0, 20);
        check("thawed", dog_irq, 1'h1);
        u_wdt_cpu.wr(`WDT_ADDR_SEL, 32'h3);
        rst_n <= 1'h0;
        @(posedge sys_clk);
        rst_n <= 1'h1;
        rdc(`WDT_ADDR_SEL, 32'h0, 32'h3);
        rdc(`WDT_ADDR_CTRL, 32'h0, 32'hF);
        wrap_up();
    end
endmodule // wdt_tb_top
